// ---- design/usc_consts.vh ----
// Constants for the serial controller: bus addresses, control word
// fields, reset values and bit-clock division factors.
// Assumes inclusion by usc_top.v only.
`ifndef USC_CONSTS_VH
`define USC_CONSTS_VH

// Address bit is the control/data select.
`define USC_ADDR_DATA   1'b0
`define USC_ADDR_CTRL   1'b1

// Mode instruction fields.
`define USC_MD_FAC_LO   1
`define USC_MD_FAC_HI   0
`define USC_MD_LEN_LO   2
`define USC_MD_LEN_HI   3
`define USC_MD_PAR_EN   4
`define USC_MD_PAR_EVEN 5
`define USC_MD_STOP_LO  6
`define USC_MD_STOP_HI  7
`define USC_MD_EXT_SYNC 6
`define USC_MD_ONE_SYNC 7

// Factor field codes; code 0 selects synchronous operation.
`define USC_FAC_SYNC    2'b00
`define USC_FAC_X16     2'b10
`define USC_FAC_X64     2'b11
`define USC_STOP_1P5    2'b10
`define USC_STOP_2      2'b11

// Command instruction bits.
`define USC_CMD_TXEN    0
`define USC_CMD_RXEN    2
`define USC_CMD_BREAK   3
`define USC_CMD_ERR_RST 4
`define USC_CMD_IRESET  6

// Reset values.
`define USC_MODE_RST    8'h00
`define USC_CMD_RST     8'h00
`define USC_SYNC_RST    8'h00

// Bit-clock edges per bit and the shortest character length.
`define USC_DIV_1       8'h01
`define USC_DIV_16      8'h10
`define USC_DIV_64      8'h40
`define USC_MIN_LEN     4'h5
`define USC_FULL_LEN    4'h8

`endif

// ---- design/usc_top.v ----
// Programmable serial controller: control word sequencing, async
// transmitter and receiver, synchronous transmitter with sync fill.
// Assumes bit clocks, serial input and clear-to-send are synchronous
// to ref_clk and much slower than it.
//
// Contract
// - Holding free flag high, cleared on data write.
// - Char available set on receive, cleared on read.
// - Characters start only with enable and clear-to-send; sync fill needs enable only.
// - Serial output marks high during reset.
// - Sync characters follow mode only in internal sync.
// - Later control writes load command words.
// - Internal reset bit returns to mode expectation.
// - Format fixed until a reset.
// - Parity not counted, never shown on bus.
// - Short characters in low bits, rest zero.
// - Async frame: start, data LSB first, parity, stops.
// - Async shifts on falling edges, divided 1/16/64.
// - Idle line high, break drives low.
// - Start on falling edge, verified at centre in 16x and 64x.
// - Sample at centres on rising edges, parity check.
// - Only first stop checked, low sets framing error.
// - Unread character overwritten, overrun flag set.
// - Error reset clears flags; errors never stall.
// - Sync output high until first character and CTS.
// - Sync shifts one bit per falling edge.
// - Sync fill when starved, drained held high.
// - Control writes with select high, data otherwise.
`timescale 1ns/1ps
`default_nettype none
`include "usc_consts.vh"

module usc_top (
    input  wire       ref_clk,
    input  wire       rstn,
    input  wire       reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       transmit_bit_clock,
    input  wire       receive_bit_clock,
    input  wire       serial_in_line,
    input  wire       clear_to_send_n,
    output reg        serial_out_line,
    output reg        transmit_holding_free,
    output reg        receive_char_available,
    output reg        transmitter_drained
);

    localparam [3:0] SQ_MODE  = 4'h1;
    localparam [3:0] SQ_SYNC1 = 4'h2;
    localparam [3:0] SQ_SYNC2 = 4'h4;
    localparam [3:0] SQ_CMD   = 4'h8;

    localparam [4:0] RX_IDLE  = 5'h01;
    localparam [4:0] RX_START = 5'h02;
    localparam [4:0] RX_DATA  = 5'h04;
    localparam [4:0] RX_PAR   = 5'h08;
    localparam [4:0] RX_STOP  = 5'h10;

    function [7:0] usc_fac;
        input [1:0] code;
        begin
            case (code)
                `USC_FAC_X16: usc_fac = `USC_DIV_16;
                `USC_FAC_X64: usc_fac = `USC_DIV_64;
                default:      usc_fac = `USC_DIV_1;
            endcase
        end
    endfunction

    // Parity bit that makes the data plus parity even or odd.
    function usc_par;
        input [7:0] d;
        input       even;
        begin
            usc_par = even ? ^d : ~^d;
        end
    endfunction

    reg  [3:0] seq_reg;
    reg  [7:0] mode_reg;
    reg  [7:0] cmd_reg;
    reg  [7:0] sync1_reg;
    reg  [7:0] sync2_reg;
    reg  [7:0] hold_reg;
    reg        hold_full_reg;
    reg        txc_prev_reg;
    reg        rxc_prev_reg;
    reg  [9:0] tx_frame_reg;
    reg  [3:0] tx_left_reg;
    reg  [7:0] tx_cnt_reg;
    reg        tx_stop_reg;
    reg        tx_busy_reg;
    reg        tx_fill_reg;
    reg        sync_run_reg;
    reg        sync_sel_reg;
    reg  [4:0] rx_state_reg;
    reg  [7:0] rx_cnt_reg;
    reg  [2:0] rx_idx_reg;
    reg  [7:0] rx_sh_reg;
    reg        rx_pbit_reg;
    reg        rx_prev_reg;
    reg        rx_seen_reg;
    reg  [7:0] rx_buf_reg;
    reg        perr_reg;
    reg        oerr_reg;
    reg        ferr_reg;

    wire [1:0] fac_code = mode_reg[`USC_MD_FAC_LO:`USC_MD_FAC_HI];
    wire       is_sync  = (fac_code == `USC_FAC_SYNC);
    wire [7:0] fac      = usc_fac(fac_code);
    wire       par_en   = mode_reg[`USC_MD_PAR_EN];
    wire       even     = mode_reg[`USC_MD_PAR_EVEN];
    wire [3:0] char_len = `USC_MIN_LEN
                        + {2'b00, mode_reg[`USC_MD_LEN_HI:`USC_MD_LEN_LO]};
    wire [7:0] len_mask = 8'hff >> (`USC_FULL_LEN - char_len);
    wire [1:0] stop_sel = mode_reg[`USC_MD_STOP_HI:`USC_MD_STOP_LO];
    // One and a half stop bits in 1x mode round down to one bit.
    wire [7:0] stop_ticks =
        (stop_sel == `USC_STOP_1P5) ? fac + (fac >> 1) :
        (stop_sel == `USC_STOP_2)   ? fac << 1 : fac;

    wire       txen     = cmd_reg[`USC_CMD_TXEN];
    wire       rxen     = cmd_reg[`USC_CMD_RXEN];
    wire       ctrl_wr  = reg_wr & (reg_addr == `USC_ADDR_CTRL);
    wire       data_wr  = reg_wr & (reg_addr == `USC_ADDR_DATA);
    wire       data_rd  = reg_rd & (reg_addr == `USC_ADDR_DATA);
    wire       tx_fall  = txc_prev_reg & ~transmit_bit_clock;
    wire       rx_rise  = ~rxc_prev_reg & receive_bit_clock;
    wire       can_send = hold_full_reg & txen & ~clear_to_send_n;

    // Data frame: start bit (async only), data LSB first, parity.
    wire [7:0] hd   = hold_reg & len_mask;
    wire       hp   = par_en & usc_par(hd, even);
    wire [9:0] dfrm = is_sync ?
                      ({2'b00, hd} | ({9'd0, hp} << char_len)) :
                      ({1'b0, hd, 1'b0} | ({9'd0, hp} << (char_len + 4'd1)));
    wire [3:0] dlen = char_len + {3'd0, par_en} + {3'd0, ~is_sync};
    wire [7:0] sd   = (sync_sel_reg ? sync2_reg : sync1_reg) & len_mask;
    wire       sp   = par_en & usc_par(sd, even);
    wire [9:0] sfrm = {2'b00, sd} | ({9'd0, sp} << char_len);
    wire [3:0] slen = char_len + {3'd0, par_en};

    wire [7:0] rx_data = rx_sh_reg & len_mask;
    wire [7:0] status  = {2'b00, ferr_reg, oerr_reg, perr_reg,
                          transmitter_drained, receive_char_available,
                          ~hold_full_reg};

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            seq_reg                <= SQ_MODE;
            mode_reg               <= `USC_MODE_RST;
            cmd_reg                <= `USC_CMD_RST;
            sync1_reg              <= `USC_SYNC_RST;
            sync2_reg              <= `USC_SYNC_RST;
            hold_reg               <= 8'h00;
            hold_full_reg          <= 1'b0;
            txc_prev_reg           <= 1'b1;
            rxc_prev_reg           <= 1'b1;
            tx_frame_reg           <= 10'h000;
            tx_left_reg            <= 4'h0;
            tx_cnt_reg             <= 8'h00;
            tx_stop_reg            <= 1'b0;
            tx_busy_reg            <= 1'b0;
            tx_fill_reg            <= 1'b0;
            sync_run_reg           <= 1'b0;
            sync_sel_reg           <= 1'b0;
            rx_state_reg           <= RX_IDLE;
            rx_cnt_reg             <= 8'h00;
            rx_idx_reg             <= 3'h0;
            rx_sh_reg              <= 8'h00;
            rx_pbit_reg            <= 1'b0;
            rx_prev_reg            <= 1'b0;
            rx_seen_reg            <= 1'b0;
            rx_buf_reg             <= 8'h00;
            perr_reg               <= 1'b0;
            oerr_reg               <= 1'b0;
            ferr_reg               <= 1'b0;
            reg_rdata              <= 8'h00;
            serial_out_line        <= 1'b1;
            transmit_holding_free  <= 1'b0;
            receive_char_available <= 1'b0;
            transmitter_drained    <= 1'b1;
        end else begin
            txc_prev_reg <= transmit_bit_clock;
            rxc_prev_reg <= receive_bit_clock;

            // Read data stands only in the cycle after the strobe.
            if (reg_rd) begin
                reg_rdata <= (reg_addr == `USC_ADDR_CTRL) ?
                             status : rx_buf_reg;
            end else begin
                reg_rdata <= 8'h00;
            end
            if (data_rd) begin
                receive_char_available <= 1'b0;
            end

            // Control word sequence after any reset.
            if (ctrl_wr) begin
                case (seq_reg)
                    SQ_MODE: begin
                        mode_reg <= reg_wdata;
                        if (reg_wdata[`USC_MD_FAC_LO:`USC_MD_FAC_HI]
                                == `USC_FAC_SYNC &&
                                !reg_wdata[`USC_MD_EXT_SYNC]) begin
                            seq_reg <= SQ_SYNC1;
                        end else begin
                            seq_reg <= SQ_CMD;
                        end
                    end
                    SQ_SYNC1: begin
                        sync1_reg <= reg_wdata;
                        seq_reg   <= mode_reg[`USC_MD_ONE_SYNC] ?
                                     SQ_CMD : SQ_SYNC2;
                    end
                    SQ_SYNC2: begin
                        sync2_reg <= reg_wdata;
                        seq_reg   <= SQ_CMD;
                    end
                    SQ_CMD: begin
                        cmd_reg <= reg_wdata;
                        if (reg_wdata[`USC_CMD_ERR_RST]) begin
                            perr_reg <= 1'b0;
                            oerr_reg <= 1'b0;
                            ferr_reg <= 1'b0;
                        end
                    end
                    default: seq_reg <= SQ_MODE;
                endcase
            end

            // Unused upper bits of a short character are dropped later.
            if (data_wr) begin
                hold_reg      <= reg_wdata;
                hold_full_reg <= 1'b1;
            end

            // Transmitter, advanced on falling bit-clock edges.
            if (tx_fall) begin
                if (tx_cnt_reg != 8'h00) begin
                    tx_cnt_reg <= tx_cnt_reg - 8'h01;
                end else if (tx_left_reg != 4'h0) begin
                    serial_out_line <= tx_frame_reg[0] &
                                       ~cmd_reg[`USC_CMD_BREAK];
                    tx_frame_reg    <= tx_frame_reg >> 1;
                    tx_left_reg     <= tx_left_reg - 4'h1;
                    tx_cnt_reg      <= fac - 8'h01;
                end else if (tx_stop_reg) begin
                    serial_out_line <= ~cmd_reg[`USC_CMD_BREAK];
                    tx_stop_reg     <= 1'b0;
                    tx_cnt_reg      <= stop_ticks - 8'h01;
                end else if (can_send) begin
                    // Loading at the boundary keeps sync data gapless.
                    serial_out_line <= dfrm[0] &
                                       ~cmd_reg[`USC_CMD_BREAK];
                    tx_frame_reg    <= dfrm >> 1;
                    tx_left_reg     <= dlen - 4'h1;
                    tx_stop_reg     <= ~is_sync;
                    tx_cnt_reg      <= fac - 8'h01;
                    tx_busy_reg     <= 1'b1;
                    tx_fill_reg     <= 1'b0;
                    sync_run_reg    <= is_sync;
                    hold_full_reg   <= data_wr;
                end else if (sync_run_reg && txen) begin
                    serial_out_line <= sfrm[0] &
                                       ~cmd_reg[`USC_CMD_BREAK];
                    tx_frame_reg    <= sfrm >> 1;
                    tx_left_reg     <= slen - 4'h1;
                    tx_cnt_reg      <= fac - 8'h01;
                    tx_fill_reg     <= 1'b1;
                    sync_sel_reg    <= ~sync_sel_reg &
                                       ~mode_reg[`USC_MD_ONE_SYNC];
                end else begin
                    serial_out_line <= ~cmd_reg[`USC_CMD_BREAK];
                    tx_busy_reg     <= 1'b0;
                    tx_fill_reg     <= 1'b0;
                    sync_run_reg    <= 1'b0;
                    sync_sel_reg    <= 1'b0;
                end
            end else if (cmd_reg[`USC_CMD_BREAK]) begin
                serial_out_line <= 1'b0;
            end else if (!tx_busy_reg) begin
                serial_out_line <= 1'b1;
            end

            // Receiver, sampled on rising bit-clock edges.
            if (rx_rise) begin
                rx_prev_reg <= serial_in_line;
                if (serial_in_line) begin
                    rx_seen_reg <= 1'b1;
                end
                case (rx_state_reg)
                    RX_IDLE: begin
                        // A held-low line after reset is not a start bit.
                        if (rxen && !is_sync && rx_seen_reg &&
                                rx_prev_reg && !serial_in_line) begin
                            rx_sh_reg  <= 8'h00;
                            rx_idx_reg <= 3'h0;
                            if (fac == `USC_DIV_1) begin
                                rx_state_reg <= RX_DATA;
                                rx_cnt_reg   <= 8'h00;
                            end else begin
                                rx_state_reg <= RX_START;
                                rx_cnt_reg   <= (fac >> 1) - 8'h01;
                            end
                        end
                    end
                    RX_START: begin
                        if (rx_cnt_reg != 8'h00) begin
                            rx_cnt_reg <= rx_cnt_reg - 8'h01;
                        end else if (!serial_in_line) begin
                            rx_state_reg <= RX_DATA;
                            rx_cnt_reg   <= fac - 8'h01;
                        end else begin
                            rx_state_reg <= RX_IDLE;
                        end
                    end
                    RX_DATA: begin
                        if (rx_cnt_reg != 8'h00) begin
                            rx_cnt_reg <= rx_cnt_reg - 8'h01;
                        end else begin
                            rx_sh_reg[rx_idx_reg] <= serial_in_line;
                            rx_cnt_reg <= fac - 8'h01;
                            if ({1'b0, rx_idx_reg} == char_len - 4'h1) begin
                                rx_state_reg <= par_en ? RX_PAR : RX_STOP;
                            end else begin
                                rx_idx_reg <= rx_idx_reg + 3'h1;
                            end
                        end
                    end
                    RX_PAR: begin
                        if (rx_cnt_reg != 8'h00) begin
                            rx_cnt_reg <= rx_cnt_reg - 8'h01;
                        end else begin
                            rx_pbit_reg  <= serial_in_line;
                            rx_cnt_reg   <= fac - 8'h01;
                            rx_state_reg <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (rx_cnt_reg != 8'h00) begin
                            rx_cnt_reg <= rx_cnt_reg - 8'h01;
                        end else begin
                            // Only the first stop bit is looked at.
                            rx_state_reg <= RX_IDLE;
                            rx_buf_reg   <= rx_data;
                            receive_char_available <= 1'b1;
                            if (receive_char_available) begin
                                oerr_reg <= 1'b1;
                            end
                            if (!serial_in_line) begin
                                ferr_reg <= 1'b1;
                            end
                            if (par_en && rx_pbit_reg !=
                                    usc_par(rx_data, even)) begin
                                perr_reg <= 1'b1;
                            end
                        end
                    end
                    default: rx_state_reg <= RX_IDLE;
                endcase
            end

            // Disabled receiver holds the available flag low.
            if (!rxen) begin
                receive_char_available <= 1'b0;
            end
            transmit_holding_free <= txen & ~hold_full_reg & ~data_wr;
            transmitter_drained   <= ~txen |
                (~hold_full_reg & ~data_wr &
                 (~tx_busy_reg | tx_fill_reg));

            // Internal reset wins over what it reloads; rx_buf_reg and the free and drained flags keep the values written above.
            if (ctrl_wr && seq_reg == SQ_CMD &&
                    reg_wdata[`USC_CMD_IRESET]) begin
                seq_reg                <= SQ_MODE;
                cmd_reg                <= `USC_CMD_RST;
                hold_full_reg          <= 1'b0;
                tx_left_reg            <= 4'h0;
                tx_cnt_reg             <= 8'h00;
                tx_stop_reg            <= 1'b0;
                tx_busy_reg            <= 1'b0;
                tx_fill_reg            <= 1'b0;
                sync_run_reg           <= 1'b0;
                sync_sel_reg           <= 1'b0;
                rx_state_reg           <= RX_IDLE;
                perr_reg               <= 1'b0;
                oerr_reg               <= 1'b0;
                ferr_reg               <= 1'b0;
                serial_out_line        <= 1'b1;
                receive_char_available <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/usc_top_monitor.sv ----
// Checker for the serial controller: bus strobes, status and line timing.
// Assumes asynchronous formats; the break tracker decodes control writes.
`timescale 1ns/1ps
`default_nettype none
module usc_top_monitor (
    input wire logic       ref_clk,
    input wire logic       rstn,
    input wire logic       reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       transmit_bit_clock,
    input wire logic       clear_to_send_n,
    input wire logic       serial_out_line,
    input wire logic       transmit_holding_free,
    input wire logic       receive_char_available,
    input wire logic       transmitter_drained
);
    logic       seen_reg;
    logic       brk_reg;
    logic [7:0] hist_reg;
    logic       tclk_reg;
    logic [3:0] age_reg;
    wire        quiet = !brk_reg && hist_reg == 8'h00;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // The first control word after any reset is a mode word, never a break.
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            seen_reg <= 1'b0;
            brk_reg  <= 1'b0;
            hist_reg <= 8'h00;
            tclk_reg <= 1'b0;
            age_reg  <= 4'hf;
        end else begin
            hist_reg <= {hist_reg[6:0], brk_reg};
            tclk_reg <= transmit_bit_clock;
            if (tclk_reg && !transmit_bit_clock)
                age_reg <= 4'h0;
            else if (age_reg != 4'hf)
                age_reg <= age_reg + 4'h1;
            if (reg_wr && reg_addr) begin
                seen_reg <= !(seen_reg && reg_wdata[6]);
                brk_reg  <= seen_reg && reg_wdata[3] && !reg_wdata[6];
            end
        end
    end
    a_reset_mark: assert property (
        $rose(rstn) |-> serial_out_line && transmitter_drained &&
        !transmit_holding_free) else $error("line not marking at reset");
    a_free_clear: assert property (
        reg_wr && !reg_addr |=> !transmit_holding_free)
        else $error("holding free stayed high after data write");
    a_avail_clear: assert property (
        reg_rd && !reg_addr && receive_char_available
        |=> !receive_char_available) else $error("available not cleared");
    a_avail_cause: assert property (
        $fell(receive_char_available) |-> $past(reg_rd && !reg_addr) ||
        $past(reg_wr && reg_addr) || $past(reg_wr && reg_addr, 2))
        else $error("available fell without a read or command");
    a_status_pins: assert property (
        reg_rd && reg_addr |=> reg_rdata[7:6] == 2'b00 && reg_rdata[2:1]
        == $past({transmitter_drained, receive_char_available}))
        else $error("status byte disagrees with pins");
    a_hold_mark: assert property (
        transmitter_drained && clear_to_send_n && quiet |=> serial_out_line)
        else $error("line left marking without clear to send");
    a_break_low: assert property (
        brk_reg[*3] |-> !serial_out_line) else $error("break not low");
    a_edge_shift: assert property (
        $changed(serial_out_line) && quiet |-> age_reg <= 4'h5)
        else $error("line changed away from a bit clock fall");
    c_data_read: cover property (reg_rd && !reg_addr && receive_char_available);
    c_break: cover property (brk_reg[*3]);
    c_frame: cover property ($fell(serial_out_line) && quiet);
endmodule
bind usc_top usc_top_monitor mon (.ref_clk(ref_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .transmit_bit_clock(transmit_bit_clock),
    .clear_to_send_n(clear_to_send_n), .serial_out_line(serial_out_line),
    .transmit_holding_free(transmit_holding_free),
    .receive_char_available(receive_char_available),
    .transmitter_drained(transmitter_drained));
`default_nettype wire

// ---- test/usc_modem.sv ----
// Far-end serial device: free-running bit clock, line driver, frame grab.
// Assumes one bit clock serves both directions at an eighth of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module usc_modem (
    input  wire logic ref_clk,
    input  wire logic tx_line,
    output wire logic bit_clk,
    output var  logic rx_line,
    output var  logic cts_n
);
    logic [2:0] div_reg = 3'h0;
    always @(posedge ref_clk) div_reg <= div_reg + 3'h1;
    assign bit_clk = div_reg[2];
    initial begin
        rx_line = 1'b1;
        cts_n = 1'b1;
    end
    // Bits change on the fall so the receiver's rising sample sits mid-bit.
    task automatic send(input logic [10:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge bit_clk);
            rx_line <= bits[i];
        end
        @(negedge bit_clk);
        rx_line <= 1'b1;
    endtask
    task automatic grab(output logic [10:0] bits, input int n);
        bits = 11'h000;
        @(negedge tx_line);
        for (int i = 0; i < n; i++) begin
            @(posedge bit_clk);
            bits[i] = tx_line;
        end
    endtask
endmodule
`default_nettype wire

// ---- test/usc_tb.sv ----
// Self-checking bench for the serial controller in 1x async and sync formats.
// Assumes the far-end model drives bit clock, receive line and CTS.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       ref_clk, rstn, reg_addr, reg_wr, reg_rd;
    logic [7:0] reg_wdata;
    wire  [7:0] reg_rdata;
    wire        bclk, rxl, cts_n, txl, free, avail, drained;
    int         mismatches = 0;
    int         checked = 0;
    int         cycles = 0;
    usc_modem modem (.ref_clk(ref_clk), .tx_line(txl), .bit_clk(bclk),
        .rx_line(rxl), .cts_n(cts_n));
    usc_top dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .transmit_bit_clock(bclk),
        .receive_bit_clock(bclk), .serial_in_line(rxl),
        .clear_to_send_n(cts_n), .serial_out_line(txl),
        .transmit_holding_free(free), .receive_char_available(avail),
        .transmitter_drained(drained));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            print_verdict;
        end
    end
    task automatic chk(input string nm, input logic [10:0] e, g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic rx_char(input logic [10:0] f, output logic [7:0] s);
        modem.send(f, 10);
        for (int i = 0; i < 200 && avail !== 1'b1; i++) @(posedge ref_clk);
        chk("available", 1, avail);
        rd(1'b1, s);
        s = s & 8'h38;
    endtask
    task automatic t_tx;
        logic [10:0] f;
        wr(1'b1, 8'h4d);
        wr(1'b1, 8'h05);
        repeat (2) @(posedge ref_clk);
        chk("free", 1, free);
        wr(1'b0, 8'ha5);
        chk("free after write", 0, free);
        repeat (64) @(posedge ref_clk);
        chk("line held", 1, txl);
        modem.cts_n <= 1'b0;
        modem.grab(f, 10);
        chk("frame", {1'b1, 8'ha5, 1'b0}, f);
        repeat (24) @(posedge ref_clk);
        chk("idle", 1, txl);
        chk("drained", 1, drained);
        $display("t_tx done");
    endtask
    task automatic t_rx;
        logic [7:0] s, d;
        rx_char({1'b1, 8'h3c, 1'b0}, s);
        rd(1'b0, d);
        chk("rx data", 8'h3c, d);
        chk("available", 0, avail);
        modem.send({1'b1, 8'h11, 1'b0}, 10);
        rx_char({1'b1, 8'h22, 1'b0}, s);
        chk("overrun", 8'h10, s);
        rd(1'b0, d);
        chk("last char", 8'h22, d);
        rx_char({1'b0, 8'h44, 1'b0}, s);
        chk("framing", 8'h30, s);
        rd(1'b0, d);
        chk("data kept", 8'h44, d);
        wr(1'b1, 8'h15);
        rd(1'b1, s);
        chk("flags cleared", 8'h00, s & 8'h38);
        $display("t_rx done");
    endtask
    task automatic t_break;
        wr(1'b1, 8'h0d);
        repeat (4) @(posedge ref_clk);
        chk("break", 0, txl);
        wr(1'b1, 8'h05);
        repeat (4) @(posedge ref_clk);
        chk("mark", 1, txl);
        $display("t_break done");
    endtask
    task automatic t_parity(input logic inner);
        logic [10:0] f;
        logic [7:0] s, d;
        wr(1'b1, 8'h79);
        wr(1'b1, 8'h05);
        wr(1'b0, 8'h83);
        modem.grab(f, 10);
        chk("parity frame", {2'b10, 7'h03, 1'b0}, f);
        if (!inner) begin
            rx_char({2'b11, 7'h55, 1'b0}, s);
            chk("parity error", 8'h08, s);
            rd(1'b0, d);
            chk("short char", 8'h55, d);
        end
        $display("t_parity done");
    endtask
    task automatic t_sync;
        logic [10:0] f;
        wr(1'b1, 8'h40);
        wr(1'b1, 8'h8c);
        wr(1'b1, 8'h96);
        wr(1'b1, 8'h01);
        wr(1'b0, 8'hda);
        modem.grab(f, 8);
        chk("sync data", 8'hda, f);
        chk("busy drained", 0, drained);
        modem.grab(f, 8);
        chk("sync fill", 8'h96, f);
        chk("fill drained", 1, drained);
        $display("t_sync done");
    endtask
    initial begin
        reg_addr = 1'b0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rstn = 1'b0;
        repeat (12) @(posedge ref_clk);
        chk("reset line", 1, txl);
        rstn <= 1'b1;
        t_tx;
        t_rx;
        t_break;
        rstn <= 1'b0;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        t_parity(1'b0);
        wr(1'b1, 8'h40);
        t_parity(1'b1);
        t_sync;
        print_verdict;
    end
endmodule
`default_nettype wire
